// *** hdl/pcs_sublayer_config_register.sv ***
// coding sublayer configuration register and the functions it steers
`include "pcs_cfg_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module pcs_sublayer_config_register (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic repeater_strap,
  input wire logic test_strap_pin,
  input wire logic legacy_mode,
  input wire pcs_cfg_pkg::reg_addr_t mgmt_addr,
  input wire logic mgmt_wr,
  input wire logic mgmt_rd,
  input wire pcs_cfg_pkg::cfg_word_t mgmt_wdata,
  input wire logic preamble_seen,
  input wire logic mgmt_frame_start,
  input wire logic tx_en,
  input wire logic tx_activity,
  input wire logic rx_dv,
  input wire logic rx_activity,
  input wire logic idle_seen,
  input wire logic descr_locked,
  input wire logic collision,
  input wire logic link_raw,
  input wire logic cim_unstable,
  input wire logic cim_status,
  input wire logic polarity_flag,
  input wire logic full_duplex,
  output pcs_cfg_pkg::cfg_word_t mgmt_rdata,
  output logic status_preamble_bit,
  output logic mgmt_frame_accept,
  output logic nrzi_enable,
  output logic descr_timeout,
  output logic carrier_sense,
  output logic collision_or_sync_indicator,
  output logic activity_indicator_pin,
  output logic duplex_indicator_pin,
  output logic regs_unlocked,
  output logic fast_timers,
  output logic ref_clock_out_pin_o,
  output logic ref_clock_out_pin_oe,
  output logic link_ok,
  output logic link_indicator,
  output logic tx_gate,
  output logic rx_gate,
  output logic digital_reset
);
  import pcs_cfg_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // register
  cfg_word_t cfg_q;
  cfg_word_t cfg_d;
  cfg_word_t reset_word;
  cfg_word_t write_mask;
  logic soft_rst_q;
  logic any_rst;
  logic strap_load_q;
  wire cfg_hit = (mgmt_addr == `CFG_REG_ADDR);
  wire cfg_wr = cfg_hit && mgmt_wr;
  wire sts_hit = (mgmt_addr == `STATUS_REG_ADDR);

  assign any_rst = rst || soft_rst_q;

  always_comb begin
    reset_word = `CFG_RESET_FIXED;
    reset_word[`BIT_REPEATER] = repeater_strap;
    reset_word[`BIT_CIM_OFF] = ~repeater_strap;
    reset_word[`BIT_CLKOUT_OFF] = ~test_strap_pin;
  end

  // legacy mode freezes the locked bits
  assign write_mask = legacy_mode ? ~`LEGACY_LOCK_MASK : 16'hffff;

  always_comb begin
    cfg_d = cfg_q;
    if (strap_load_q) begin
      cfg_d = reset_word;
    end else if (cfg_wr) begin
      cfg_d = (cfg_q & ~write_mask) | (mgmt_wdata & write_mask);
    end
  end

  // straps are caught by a clocked load one cycle after reset release
  always_ff @(posedge core_clk) begin
    if (any_rst) begin
      cfg_q <= `CFG_RESET_FIXED;
      strap_load_q <= 1'b1;
    end else if (clk_en) begin
      cfg_q <= cfg_d;
      strap_load_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      soft_rst_q <= 1'b0;
    end else if (clk_en) begin
      soft_rst_q <= cfg_wr && write_mask[`BIT_DIG_RESET]
        && mgmt_wdata[`BIT_DIG_RESET];
    end
  end

  // locked functions read as held but act disabled in legacy mode
  wire ind5_mode = cfg_q[`BIT_IND5_MODE] && !legacy_mode;
  wire unlock = cfg_q[`BIT_UNLOCK] && !legacy_mode;
  wire pre_req = cfg_q[`BIT_PREAMBLE_REQ] && !legacy_mode;
  wire fast = cfg_q[`BIT_FAST_TEST] && !legacy_mode;

  ////////////////////////////////////////////////////////////////////////
  // descrambler time-out counter
  localparam int LONG_CYC = `TO_LONG_CYC;
  localparam int SHORT_CYC = `TO_SHORT_CYC;
  logic [15:0] to_cnt_q;
  logic to_q;
  wire [15:0] to_limit_full = cfg_q[`BIT_TO_SELECT] ?
    16'(LONG_CYC) : 16'(SHORT_CYC);
  wire [15:0] to_limit = fast ?
    (to_limit_full >> `FAST_TEST_SHIFT) : to_limit_full;
  wire to_run = !cfg_q[`BIT_TO_DISABLE];
  wire to_hit = to_run && (to_cnt_q >= to_limit - 16'h0001);

  always_ff @(posedge core_clk) begin
    if (any_rst) begin
      to_cnt_q <= 16'h0000;
      to_q <= 1'b0;
    end else if (clk_en) begin
      if (idle_seen || !to_run) begin
        to_cnt_q <= 16'h0000;
        to_q <= 1'b0;
      end else if (to_hit) begin
        to_q <= 1'b1;
      end else begin
        to_cnt_q <= to_cnt_q + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // management preamble check
  logic [5:0] ones_q;
  wire pre_ok = (ones_q >= 6'(`PREAMBLE_BITS));

  always_ff @(posedge core_clk) begin
    if (any_rst) begin
      ones_q <= 6'h00;
    end else if (clk_en) begin
      if (mgmt_frame_start) begin
        ones_q <= 6'h00;
      end else if (preamble_seen) begin
        if (!pre_ok) begin
          ones_q <= ones_q + 6'h01;
        end
      end else begin
        ones_q <= 6'h00;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // packet gates
  logic tx_pass;
  logic rx_pass;
  wire cim_block = !cfg_q[`BIT_CIM_OFF] && cim_unstable;

  packet_gate u_tx_gate (
    .core_clk(core_clk),
    .rst(any_rst),
    .clk_en(clk_en),
    .block_req(cfg_q[`BIT_TX_OFF] || cim_block),
    .frame_active(tx_en),
    .pass(tx_pass)
  );

  packet_gate u_rx_gate (
    .core_clk(core_clk),
    .rst(any_rst),
    .clk_en(clk_en),
    .block_req(cfg_q[`BIT_RX_OFF] || cim_block),
    .frame_active(rx_dv),
    .pass(rx_pass)
  );

  ////////////////////////////////////////////////////////////////////////
  // output decode
  wire link_d = !cfg_q[`BIT_LINK_CHECK] || link_raw;
  wire crs_d = cfg_q[`BIT_REPEATER] ? rx_activity :
    (rx_activity || tx_activity);
  wire ind5_d = ind5_mode ? descr_locked : collision;
  wire ind1_d = cfg_q[`BIT_IND1_MODE] ? cim_status : tx_activity;
  wire ind4_d = cfg_q[`BIT_IND4_MODE] ? full_duplex :
    (full_duplex || polarity_flag);
  wire accept_d = mgmt_frame_start && (!pre_req || pre_ok);
  wire [15:0] rdata_d = cfg_hit ? cfg_q :
    (sts_hit ? (16'h0000 | (16'(!pre_req) << `STATUS_PREAMBLE_BIT)) :
    16'h0000);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      mgmt_rdata <= 16'h0000;
      status_preamble_bit <= 1'b1;
      mgmt_frame_accept <= 1'b0;
      nrzi_enable <= 1'b1;
      descr_timeout <= 1'b0;
      carrier_sense <= 1'b0;
      collision_or_sync_indicator <= 1'b0;
      activity_indicator_pin <= 1'b0;
      duplex_indicator_pin <= 1'b0;
      regs_unlocked <= 1'b0;
      fast_timers <= 1'b0;
      ref_clock_out_pin_o <= 1'b0;
      ref_clock_out_pin_oe <= 1'b0;
      link_ok <= 1'b0;
      link_indicator <= 1'b0;
      tx_gate <= 1'b0;
      rx_gate <= 1'b0;
      digital_reset <= 1'b0;
    end else if (clk_en) begin
      if (mgmt_rd) begin
        mgmt_rdata <= rdata_d;
      end
      status_preamble_bit <= !pre_req;
      mgmt_frame_accept <= accept_d;
      nrzi_enable <= cfg_q[`BIT_NRZI_EN];
      descr_timeout <= to_q;
      carrier_sense <= crs_d;
      collision_or_sync_indicator <= ind5_d;
      activity_indicator_pin <= ind1_d;
      duplex_indicator_pin <= ind4_d;
      regs_unlocked <= unlock;
      fast_timers <= fast;
      ref_clock_out_pin_o <= !ref_clock_out_pin_o;
      ref_clock_out_pin_oe <= !cfg_q[`BIT_CLKOUT_OFF];
      link_ok <= link_d;
      link_indicator <= link_d;
      tx_gate <= tx_pass;
      rx_gate <= rx_pass;
      digital_reset <= soft_rst_q;
    end
  end
endmodule
`default_nettype wire

// *** hdl/pcs_cfg_consts.svh ***
// constants for the coding sublayer configuration register
`ifndef PCS_CFG_CONSTS_SVH
`define PCS_CFG_CONSTS_SVH
`define CFG_REG_ADDR 5'h17
`define STATUS_REG_ADDR 5'h01
`define STATUS_PREAMBLE_BIT 6
`define BIT_NRZI_EN 15
`define BIT_TO_SELECT 14
`define BIT_TO_DISABLE 13
`define BIT_REPEATER 12
`define BIT_IND5_MODE 11
`define BIT_UNLOCK 10
`define BIT_PREAMBLE_REQ 9
`define BIT_FAST_TEST 8
`define BIT_CLKOUT_OFF 7
`define BIT_LINK_CHECK 6
`define BIT_CIM_OFF 5
`define BIT_TX_OFF 4
`define BIT_RX_OFF 3
`define BIT_IND1_MODE 2
`define BIT_IND4_MODE 1
`define BIT_DIG_RESET 0
`define CFG_RESET_FIXED 16'h8040
`define LEGACY_LOCK_MASK 16'h0f01
`define CLK_PERIOD_NS 50
`define TO_LONG_US 2000
`define TO_SHORT_US 722
`define TO_LONG_CYC ((`TO_LONG_US * 1000) / `CLK_PERIOD_NS)
`define TO_SHORT_CYC ((`TO_SHORT_US * 1000) / `CLK_PERIOD_NS)
`define FAST_TEST_SHIFT 6
`define PREAMBLE_BITS 32
`endif

// *** hdl/pcs_cfg_pkg.sv ***
// types for the coding sublayer configuration register
package pcs_cfg_pkg;
  typedef logic [15:0] cfg_word_t;
  typedef logic [4:0] reg_addr_t;
  typedef enum logic [1:0] {
    GATE_OPEN = 2'b00,
    GATE_DRAIN = 2'b01,
    GATE_SHUT = 2'b10
  } gate_state_t;
endpackage

// *** hdl/packet_gate.sv ***
// gate that opens and shuts only at packet boundaries
`timescale 1ns/100ps
`default_nettype none
module packet_gate (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic block_req,
  input wire logic frame_active,
  output logic pass
);
  import pcs_cfg_pkg::*;
  gate_state_t state_q;
  gate_state_t state_d;

  always_comb begin
    state_d = state_q;
    case (state_q)
      GATE_OPEN: begin
        if (block_req && frame_active) begin
          state_d = GATE_DRAIN;
        end else if (block_req) begin
          state_d = GATE_SHUT;
        end
      end
      GATE_DRAIN: begin
        if (!frame_active) begin
          state_d = GATE_SHUT;
        end
      end
      GATE_SHUT: begin
        // reopen only between frames so no fragment escapes
        if (!block_req && !frame_active) begin
          state_d = GATE_OPEN;
        end
      end
      default: state_d = GATE_SHUT;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q <= GATE_OPEN;
    end else if (clk_en) begin
      state_q <= state_d;
    end
  end

  assign pass = (state_q != GATE_SHUT);
endmodule
`default_nettype wire

// *** verif/mgmt_station_model.sv ***
// management station model: preamble ones followed by a frame start
`timescale 1ns/100ps
`default_nettype none
module mgmt_station_model (
  input wire logic core_clk,
  input wire logic go,
  input wire logic [5:0] pre_len,
  output logic preamble_seen,
  output logic mgmt_frame_start
);
  initial begin
    preamble_seen = 1'b0;
    mgmt_frame_start = 1'b0;
    forever begin
      @(posedge core_clk);
      if (go) begin
        repeat (pre_len) begin
          @(negedge core_clk);
          preamble_seen = 1'b1;
        end
        @(negedge core_clk);
        preamble_seen = 1'b0;
        mgmt_frame_start = 1'b1;
        @(negedge core_clk);
        mgmt_frame_start = 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// *** verif/pcs_cfg_asserts.sv ***
// assertions on the configuration register ports
`timescale 1ns/100ps
`default_nettype none
module pcs_cfg_asserts (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic legacy_mode,
  input wire pcs_cfg_pkg::reg_addr_t mgmt_addr,
  input wire logic mgmt_wr,
  input wire logic mgmt_rd,
  input wire pcs_cfg_pkg::cfg_word_t mgmt_wdata,
  input wire logic preamble_seen,
  input wire logic mgmt_frame_start,
  input wire logic tx_en,
  input wire logic rx_dv,
  input wire pcs_cfg_pkg::cfg_word_t mgmt_rdata,
  input wire logic status_preamble_bit,
  input wire logic mgmt_frame_accept,
  input wire logic nrzi_enable,
  input wire logic ref_clock_out_pin_oe,
  input wire logic tx_gate,
  input wire logic rx_gate
);
  import pcs_cfg_pkg::*;
  logic [5:0] pre_cnt_q;
  logic [5:0] pre_cnt_d;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // run of consecutive preamble ones, held over the frame start
  assign pre_cnt_d = preamble_seen ? pre_cnt_q + (pre_cnt_q != 6'h3f) :
    (mgmt_frame_start ? pre_cnt_q : 6'h00);
  always_ff @(posedge core_clk) begin
    pre_cnt_q <= rst ? 6'h00 : pre_cnt_d;
  end
  ////////////////////
  sequence s_wr;
    clk_en && mgmt_wr && mgmt_addr == 5'h17 && !legacy_mode &&
      !mgmt_wdata[0] ##1 !mgmt_wr && clk_en && !legacy_mode;
  endsequence
  sequence s_frame;
    clk_en && mgmt_frame_start;
  endsequence
  property p_nrzi;
    s_wr |=> nrzi_enable == $past(mgmt_wdata[15], 2);
  endproperty
  a_nrzi: assert property (p_nrzi) else $error("nrzi enable wrong");
  property p_status;
    s_wr |=> status_preamble_bit == !$past(mgmt_wdata[9], 2);
  endproperty
  a_status: assert property (p_status) else $error("status bit");
  property p_oe;
    s_wr |=> ref_clock_out_pin_oe == !$past(mgmt_wdata[7], 2);
  endproperty
  a_oe: assert property (p_oe) else $error("clock out enable");
  property p_tx_hold;
    tx_en [*3] ##0 tx_gate |=> tx_gate || !tx_en;
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx cut");
  property p_tx_wait;
    (tx_en && !tx_gate) [*2] |=> !tx_gate;
  endproperty
  a_tx_wait: assert property (p_tx_wait) else $error("tx fragment");
  property p_rx_wait;
    (rx_dv && !rx_gate) [*2] |=> !rx_gate;
  endproperty
  a_rx_wait: assert property (p_rx_wait) else $error("rx fragment");
  property p_pre_need;
    s_frame ##0 !status_preamble_bit && pre_cnt_q < 6'd32 |=>
      !mgmt_frame_accept;
  endproperty
  a_pre_need: assert property (p_pre_need) else $error("short");
  property p_unmapped;
    clk_en && mgmt_rd && mgmt_addr != 5'h17 && mgmt_addr != 5'h01 |=>
      mgmt_rdata == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped");
endmodule
bind pcs_sublayer_config_register pcs_cfg_asserts i_pcs_cfg_asserts (.*);
`default_nettype wire

// *** verif/pcs_sublayer_config_register_bench.sv ***
// bench for the coding sublayer configuration register
`timescale 1ns/100ps
`default_nettype none
module pcs_sublayer_config_register_bench;
  import pcs_cfg_pkg::*;
  logic core_clk, rst, clk_en, repeater_strap, test_strap_pin, legacy_mode;
  logic mgmt_wr, mgmt_rd, tx_en, tx_activity, rx_dv, rx_activity, idle_seen;
  logic descr_locked, collision, link_raw, cim_unstable, cim_status;
  logic polarity_flag, full_duplex, go, acc_seen, preamble_seen;
  logic mgmt_frame_start, status_preamble_bit, mgmt_frame_accept;
  logic nrzi_enable, descr_timeout, carrier_sense, regs_unlocked;
  logic collision_or_sync_indicator, activity_indicator_pin;
  logic duplex_indicator_pin, fast_timers, ref_clock_out_pin_o;
  logic ref_clock_out_pin_oe, link_ok, link_indicator;
  logic tx_gate, rx_gate, digital_reset, rst_seen, clk_prev;
  reg_addr_t mgmt_addr;
  cfg_word_t mgmt_wdata, mgmt_rdata;
  logic [5:0] pre_len;
  int mismatches, cmp_count, cyc;
  pcs_sublayer_config_register i_pcs_sublayer_config_register (.*);
  mgmt_station_model i_mgmt_station_model (.*);
  ////////////////////
  task automatic complete_run;
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input string w, input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", w, e, s);
    end
  endtask
  task automatic b(input string w, input logic s, input logic e);
    chk(w, {15'h0, s}, {15'h0, e});
  endtask
  task automatic wr(input cfg_word_t d);
    @(negedge core_clk);
    mgmt_addr = 5'h17;
    mgmt_wdata = d;
    mgmt_wr = 1'b1;
    @(negedge core_clk);
    mgmt_wr = 1'b0;
    repeat (3) @(negedge core_clk);
  endtask
  task automatic rd(input reg_addr_t a, input cfg_word_t e);
    @(negedge core_clk);
    mgmt_addr = a;
    mgmt_rd = 1'b1;
    @(negedge core_clk);
    mgmt_rd = 1'b0;
    chk("rdata", mgmt_rdata, e);
  endtask
  task automatic send(input logic [5:0] n, input logic e);
    pre_len = n;
    acc_seen = 1'b0;
    go = 1'b1;
    @(negedge core_clk);
    go = 1'b0;
    repeat (40) @(negedge core_clk);
    b("accept", acc_seen, e);
  endtask
  // sel 0 works the transmit side, 1 the receive side
  task automatic gate(input logic sel, input cfg_word_t blk);
    {rx_dv, tx_en} = sel ? 2'b10 : 2'b01;
    wr(blk);
    b("gate", sel ? rx_gate : tx_gate, 1'b1);
    {rx_dv, tx_en} = 2'b00;
    repeat (4) @(negedge core_clk);
    b("gate", sel ? rx_gate : tx_gate, 1'b0);
    {rx_dv, tx_en} = sel ? 2'b10 : 2'b01;
    wr(16'h0040);
    b("gate", sel ? rx_gate : tx_gate, 1'b0);
    {rx_dv, tx_en} = 2'b00;
    repeat (4) @(negedge core_clk);
    b("gate", sel ? rx_gate : tx_gate, 1'b1);
  endtask
  task automatic idle_wait(input cfg_word_t c, input int n, input logic e);
    idle_seen = 1'b1;
    wr(c);
    idle_seen = 1'b0;
    repeat (n) @(negedge core_clk);
    b("timeout", descr_timeout, e);
  endtask
  ////////////////////
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (mgmt_frame_accept === 1'b1) acc_seen = 1'b1;
    if (digital_reset === 1'b1) rst_seen = 1'b1;
    if (cyc == 70000) begin
      mismatches++;
      complete_run;
    end
  end
  initial begin
    {rst, clk_en, repeater_strap, test_strap_pin} = 4'b1110;
    {legacy_mode, mgmt_wr, mgmt_rd, tx_en, rx_dv, rx_activity} = '0;
    {idle_seen, descr_locked, collision, link_raw, cim_unstable} = 5'b01000;
    {cim_status, polarity_flag, full_duplex, go, acc_seen} = '0;
    tx_activity = 1'b1;
    mgmt_addr = '0;
    mgmt_wdata = '0;
    pre_len = '0;
    rst_seen = 1'b0;
    repeat (10) @(negedge core_clk);
    rst = 1'b0;
    repeat (2) @(negedge core_clk);
    rd(5'h17, 16'h90c0);
    b("nrzi", nrzi_enable, 1'b1);
    b("clk_oe", ref_clock_out_pin_oe, 1'b0);
    b("crs", carrier_sense, 1'b0);
    b("ind1", activity_indicator_pin, 1'b1);
    b("ind4", duplex_indicator_pin, 1'b0);
    polarity_flag = 1'b1;
    repeat (2) @(negedge core_clk);
    b("ind4", duplex_indicator_pin, 1'b1);
    polarity_flag = 1'b0;
    clk_prev = ref_clock_out_pin_o;
    @(negedge core_clk);
    b("clk_out", ref_clock_out_pin_o, !clk_prev);
    wr(16'h0040);
    b("crs", carrier_sense, 1'b1);
    b("nrzi", nrzi_enable, 1'b0);
    wr(16'h0a40);
    b("ind5", collision_or_sync_indicator, 1'b1);
    rd(5'h01, 16'h0000);
    send(6'd31, 1'b0);
    send(6'd32, 1'b1);
    wr(16'h0040);
    rd(5'h01, 16'h0040);
    b("ind5", collision_or_sync_indicator, 1'b0);
    collision = 1'b1;
    repeat (2) @(negedge core_clk);
    b("ind5", collision_or_sync_indicator, 1'b1);
    collision = 1'b0;
    send(6'd0, 1'b1);
    wr(16'h0540);
    b("unlock", regs_unlocked, 1'b1);
    b("fast", fast_timers, 1'b1);
    legacy_mode = 1'b1;
    wr(16'h0040);
    rd(5'h17, 16'h0540);
    b("unlock", regs_unlocked, 1'b0);
    legacy_mode = 1'b0;
    idle_wait(16'h0540, 260, 1'b1);
    idle_wait(16'h0040, 14380, 1'b0);
    repeat (120) @(negedge core_clk);
    b("timeout", descr_timeout, 1'b1);
    idle_wait(16'h2040, 15000, 1'b0);
    wr(16'h0000);
    b("link", link_ok & link_indicator, 1'b1);
    wr(16'h0040);
    b("link", link_ok, 1'b0);
    gate(1'b0, 16'h0050);
    gate(1'b1, 16'h0048);
    cim_unstable = 1'b1;
    repeat (5) @(negedge core_clk);
    b("cim", tx_gate | rx_gate, 1'b0);
    wr(16'h0060);
    repeat (3) @(negedge core_clk);
    b("cim", tx_gate & rx_gate, 1'b1);
    rd(5'h05, 16'h0000);
    wr(16'h0001);
    rd(5'h17, 16'h90c0);
    b("dig_rst", rst_seen, 1'b1);
    complete_run;
  end
endmodule
`default_nettype wire
